/* logic/sss_slots.v */
// sequencer stack slots 23..25 with apb register access and step selection
`timescale 1ns/1ps

`include "sss_consts.vh"

module sss_slots (
  // apb clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // apb request
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  // apb answer
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  // sequencer control
  input  wire        seq_restart,
  input  wire        conv_done,
  // sequencer step outputs
  output reg  [1:0]  active_slot,
  output reg  [3:0]  converter_a_input_pick,
  output reg  [3:0]  converter_b_input_pick
);

  // bus decode
  wire                      setup_ph;
  wire                      access_ph;
  wire [5:0]                reg_idx;
  wire                      aligned;
  wire                      stat_hit;
  wire                      mapped;
  wire [8:0]                wr_body;

  // slot storage view
  wire [15:0]               slot_word [0:`SSS_NUM_SLOTS-1];
  wire [`SSS_NUM_SLOTS-1:0] slot_hit;
  wire [`SSS_NUM_SLOTS-1:0] slot_wr;

  // read path
  wire [15:0]               stat_word;
  reg  [15:0]               rd_word;

  // step selection
  reg  [1:0]                active_slot_nxt;
  wire [15:0]               cur_word;
  wire [15:0]               nxt_word;
  wire                      cur_wrap;
  wire                      at_last;
  // reasons for a slot change
  wire                      step_restart;
  wire                      step_wrap;
  wire                      step_end;
  wire                      step_fwd;
  wire [3:0]                nxt_pick_a;
  wire [3:0]                nxt_pick_b;

  // address decode
  assign setup_ph  = psel & ~penable;
  assign access_ph = psel & penable;
  assign reg_idx   = paddr[7:2];
  // only word-aligned offsets inside the low 256 bytes are decoded
  assign aligned   = (paddr[1:0] == 2'h0) &
                     (paddr[11:8] == 4'h0);
  assign stat_hit  = aligned &
                     (reg_idx == `SSS_IDX_STATUS);
  assign mapped    = stat_hit |
                     (|slot_hit);
  // storage keeps bits 8..0 only; the rest is fixed per slot
  assign wr_body   = pwdata[8:0];

  // one storage entry per slot
  genvar g;
  generate
    for (g = 0; g < `SSS_NUM_SLOTS; g = g + 1) begin : g_slot
      localparam [15:0] RST  = (g == 0) ? `SSS_RST_SLOT23 :
                               (g == 1) ? `SSS_RST_SLOT24 :
                                          `SSS_RST_SLOT25;
      localparam [5:0]  SELF = RST[`SSS_ADDR_HI:`SSS_ADDR_LO];

      reg  [8:0] body_r;
      wire       dir_wr;
      wire       self_ok;

      assign slot_hit[g] = aligned &
                           (reg_idx == SELF);
      // a write needs the direction bit and the entry's own address in the word
      assign dir_wr     = pwdata[`SSS_BIT_DIR];
      assign self_ok    = (pwdata[`SSS_ADDR_HI:`SSS_ADDR_LO] == SELF);
      assign slot_wr[g] = access_ph &
                          pwrite &
                          slot_hit[g] &
                          dir_wr &
                          self_ok;

      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          body_r <= RST[8:0];
        end else if (slot_wr[g]) begin
          body_r <= wr_body;
        end
      end

      // direction bit reads back zero; address field is fixed
      assign slot_word[g] = {1'b0,
                             SELF,
                             body_r};
    end
  endgenerate

  // zero wait states; unmapped or misaligned accesses are flagged
  assign pready  = 1'b1;
  assign pslverr = access_ph &
                   ~mapped;

  // status word: active slot and the picks now in force
  assign stat_word = {6'h00,
                      active_slot,
                      converter_b_input_pick,
                      converter_a_input_pick};

  // decode is one-hot, so at most one word is selected
  always @* begin
    rd_word = 16'h0000;
    case ({stat_hit, slot_hit})
      4'h1: begin
        rd_word = slot_word[0];
      end

      4'h2: begin
        rd_word = slot_word[1];
      end

      4'h4: begin
        rd_word = slot_word[2];
      end

      4'h8: begin
        rd_word = stat_word;
      end

      default: begin
        rd_word = 16'h0000;
      end
    endcase
  end

  // read data captured in the setup phase and held through the access phase
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup_ph) begin
      prdata <= {16'h0000,
                 rd_word};
    end
  end

  // step selection
  assign cur_word   = slot_word[active_slot];
  assign nxt_word   = slot_word[active_slot_nxt];
  assign cur_wrap   = cur_word[`SSS_BIT_WRAP];
  assign at_last    = (active_slot == `SSS_LAST_SLOT);
  assign nxt_pick_a = nxt_word[`SSS_PICK_A_HI:`SSS_PICK_A_LO];
  assign nxt_pick_b = nxt_word[`SSS_PICK_B_HI:`SSS_PICK_B_LO];

  // restart wins over a finished conversion on the same edge
  assign step_restart = seq_restart;
  assign step_wrap    = ~seq_restart & conv_done & cur_wrap;
  // slots past this bank are not held here, so the last one returns to the first
  assign step_end     = ~seq_restart & conv_done & ~cur_wrap & at_last;
  assign step_fwd     = ~seq_restart & conv_done & ~cur_wrap & ~at_last;

  always @* begin
    active_slot_nxt = active_slot;
    if (step_restart | step_wrap | step_end) begin
      active_slot_nxt = 2'h0;
    end else if (step_fwd) begin
      active_slot_nxt = active_slot + 2'h1;
    end else begin
      active_slot_nxt = active_slot;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active_slot <= 2'h0;
    end else begin
      active_slot <= active_slot_nxt;
    end
  end

  // converter A pick follows the entry that becomes active, rewrites included
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      converter_a_input_pick <= 4'h0;
    end else begin
      converter_a_input_pick <= nxt_pick_a;
    end
  end

  // converter B pick follows the same entry
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      converter_b_input_pick <= 4'h0;
    end else begin
      converter_b_input_pick <= nxt_pick_b;
    end
  end

endmodule // sss_slots

/* logic/sss_consts.vh */
// constants for the sequencer stack slot bank
`ifndef SSS_CONSTS_VH
`define SSS_CONSTS_VH
// register indices; byte address is four times the index
`define SSS_IDX_SLOT23      6'h37
`define SSS_IDX_SLOT24      6'h38
`define SSS_IDX_SLOT25      6'h39
`define SSS_IDX_STATUS      6'h3F
// reset words
`define SSS_RST_SLOT23      16'h6E00
`define SSS_RST_SLOT24      16'h7000
`define SSS_RST_SLOT25      16'h7200
// field positions
`define SSS_BIT_DIR         15
`define SSS_ADDR_HI         14
`define SSS_ADDR_LO         9
`define SSS_BIT_WRAP        8
`define SSS_PICK_B_HI       7
`define SSS_PICK_B_LO       4
`define SSS_PICK_A_HI       3
`define SSS_PICK_A_LO       0
`define SSS_NUM_SLOTS       3
`define SSS_LAST_SLOT       2'h2
`endif

/* tb/sss_chk_assertions.sv */
// assertion checker for the slot bank
`timescale 1ns/1ps
module sss_chk (
  // clock and reset
  input wire        pclk,
  input wire        presetn,
  // bus
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  // sequencer
  input wire        seq_restart,
  input wire        conv_done,
  input wire [1:0]  active_slot
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence apb_access;
    psel && penable;
  endsequence
  sequence slot23_read;
    psel && penable && !pwrite && paddr == 12'h0DC;
  endsequence
  sequence stray_access;
    psel && penable && paddr == 12'h100;
  endsequence
  sequence step_taken;
    conv_done && !seq_restart;
  endsequence
  ready_high_a: assert property (apb_access |-> pready) else $error("no ready in access");
  stray_error_a: assert property (stray_access |-> pslverr) else $error("stray access not flagged");
  self_field_a: assert property (slot23_read |-> prdata[15:9] == 7'h37) else $error("self field wrong");
  step_order_a: assert property (step_taken |=> active_slot == $past(active_slot) + 2'h1 || active_slot == 2'h0)
    else $error("step out of order");
  slot_range_a: assert property (active_slot != 2'h3) else $error("slot out of range");
  restart_zero_a: assert property (seq_restart |=> active_slot == 2'h0) else $error("restart missed");
  idle_hold_a: assert property (!conv_done && !seq_restart |=> $stable(active_slot)) else $error("slot moved");
  upper_zero_a: assert property (psel && penable && !pwrite |-> prdata[31:16] == 16'h0) else $error("upper bits");
endmodule // sss_chk
bind sss_slots sss_chk i_sss_chk (.pclk(pclk), .presetn(presetn), .seq_restart(seq_restart), .conv_done(conv_done),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .active_slot(active_slot));

/* tb/sss_conv.sv */
// converter side: one conversion-done pulse per request
`timescale 1ns/1ps
module sss_conv (
  input wire pclk, input wire go, output reg conv_done
);
  initial conv_done = 1'b0;
  always @(posedge pclk) conv_done <= go;
endmodule // sss_conv

/* tb/sequencer_stack_slots_bench.sv */
// bench for the slot bank
`timescale 1ns/1ps
module sequencer_stack_slots_bench;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, seq_restart = 1, go = 0, conv_done, pready, pslverr;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, r;
  logic [1:0] active_slot;
  logic [3:0] pa, pb;
  int miscompares = 0, n_checks = 0;
  sss_slots i_sss_slots (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .seq_restart(seq_restart),
    .conv_done(conv_done), .active_slot(active_slot), .converter_a_input_pick(pa), .converter_b_input_pick(pb));
  sss_conv i_sss_conv (.pclk(pclk), .go(go), .conv_done(conv_done));
  initial forever #20 pclk = ~pclk;
  task ck(input [31:0] g, input [31:0] e); begin
    n_checks++;
    if (g !== e) begin miscompares++; $display("[FAIL] %0t got %h want %h", $time, g, e); end
  end endtask
  task acc(input w, input [11:0] a, input [31:0] d); begin
    @(posedge pclk); psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk); penable <= 1;
    @(posedge pclk); while (pready !== 1'b1) @(posedge pclk);
    r = pslverr ? 32'hFFFF_FFFF : prdata; psel <= 0; penable <= 0;
  end endtask
  task step(input [1:0] s, input [7:0] p); begin
    @(posedge pclk); go <= 1; @(posedge pclk); go <= 0; repeat (2) @(posedge pclk); #1;
    ck(active_slot, s); ck({pb, pa}, p);
  end endtask
  task t_reset; begin
    acc(0, 12'hDC, 0); ck(r, 32'h6E00); acc(0, 12'hE0, 0); ck(r, 32'h7000);
    acc(0, 12'hE4, 0); ck(r, 32'h7200); acc(0, 12'h100, 0); ck(r, 32'hFFFF_FFFF);
    $display("reset test done");
  end endtask
  task t_write; begin
    acc(1, 12'hDC, 32'hEE21); acc(1, 12'hDC, 32'hF055); acc(1, 12'hDC, 32'h6E77);
    acc(0, 12'hDC, 0); ck(r, 32'h6E21); acc(1, 12'hE0, 32'hF143); acc(0, 12'hE0, 0); ck(r, 32'h7143);
    $display("write test done");
  end endtask
  task t_seq; begin
    @(posedge pclk); seq_restart <= 1; @(posedge pclk); seq_restart <= 0;
    step(2'h1, 8'h43); step(2'h0, 8'h21); step(2'h1, 8'h43);
    $display("sequence test done");
  end endtask
  task t_wrap; begin
    acc(1, 12'hE0, 32'hF065); acc(1, 12'hE4, 32'hF298);
    @(posedge pclk); seq_restart <= 1; @(posedge pclk); seq_restart <= 0;
    step(2'h1, 8'h65); step(2'h2, 8'h98); step(2'h0, 8'h21);
    acc(0, 12'hFC, 0); ck(r, 32'h21);
    $display("wrap test done");
  end endtask
  task t_rerun; begin
    @(posedge pclk); presetn <= 0; repeat (2) @(posedge pclk); presetn <= 1;
    ck({pb, pa}, 0);
    acc(0, 12'hDC, 0); ck(r, 32'h6E00); acc(0, 12'hE0, 0); ck(r, 32'h7000);
    acc(0, 12'hE4, 0); ck(r, 32'h7200); acc(0, 12'hFC, 0); ck(r, 32'h0);
    $display("reset rerun test done");
  end endtask
  task close_out; begin
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  end endtask
  initial begin
    repeat (4) @(posedge pclk); presetn <= 1; seq_restart <= 0;
    t_reset; t_write; t_seq; t_wrap; t_rerun; close_out;
  end
  initial begin #200000; miscompares++; close_out; end
endmodule // sequencer_stack_slots_bench
